// file: logic/poc_map.vh
// Register offsets, field positions, reset values and timing counts of the proximity offset calibration block.
`ifndef POC_MAP_VH
`define POC_MAP_VH
// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define POC_ADDR_OFFSET_MAG  8'hc0
`define POC_ADDR_OFFSET_SIGN 8'hc1
`define POC_ADDR_CALIB_CTRL  8'hd7
`define POC_ADDR_CALIB_CFG   8'hd9
`define POC_ADDR_CALIB_STAT  8'hdc
`define POC_ADDR_INT_EN      8'hdd
`define POC_ADDR_MAVG        8'hb3
`define POC_ADDR_LOT_LOW     8'he5
// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define POC_CTRL_START_BIT   0
`define POC_CTRL_ELEC_BIT    5
`define POC_CFG_AUTO_BIT     3
`define POC_STAT_DEC_BIT     2
`define POC_STAT_DONE_BIT    0
`define POC_IEN_MODE_BIT     5
`define POC_IEN_PROX_BIT     4
`define POC_IEN_SAT_BIT      3
`define POC_IEN_CAL_BIT      2
`define POC_IEN_ZERO_BIT     1
// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define POC_RST_CALIB_CFG    8'h50
`define POC_RST_CALIB_CTRL   8'h00
`define POC_RST_CALIB_STAT   8'h00
`define POC_RST_INT_EN       8'h00
`define POC_RST_MAVG         8'h00
`define POC_LOT_LOW_VALUE    8'h5a
// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define POC_CLK_MHZ          50
`define POC_SETTLE_NS        200
`define POC_SETTLE_CYC       ((`POC_SETTLE_NS * `POC_CLK_MHZ + 999) / 1000)
`endif

// file: logic/poc_calib.v
// Proximity offset calibration, sample averaging and interrupt enable logic.
`include "poc_map.vh"
module poc_calib (
  // Clock and reset.
  input  wire        clk,
  input  wire        srst,
  // Register port.
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [7:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  output reg  [7:0]  reg_rdata_q,
  // Front end: sample request, raw sample with offset applied, sample strobe.
  output reg         sample_req_q,
  output reg         photodiode_connect_q,
  input  wire [9:0]  adc_sample,
  input  wire        adc_valid,
  // Hardware averaged value and whether it goes to the moving filter.
  output reg  [9:0]  avg_out_q,
  output reg         avg_valid_q,
  output reg         avg_to_filter_q,
  // Proximity result from the filter stage and status inputs.
  input  wire [9:0]  proximity_result,
  input  wire        proximity_result_valid,
  input  wire        prox_event,
  input  wire        sat_event,
  input  wire        zero_event,
  input  wire        calibration_irq_clear,
  // Offset and status outputs.
  output reg  [7:0]  offset_magnitude_q,
  output reg         offset_sign_q,
  output reg         calibration_irq_status_q,
  output reg         proximity_irq_status_q,
  output reg         irq_n_q,
  output reg         calib_busy_q
);
  // --------------------------------------------------------------------------
  // Functions
  // --------------------------------------------------------------------------
  // Target value for a search code: two to the code plus two, minus one.
  function [9:0] target_of;
    input [2:0] code;
    begin
      target_of = (10'h004 << code) - 10'h001;
    end
  endfunction

  // Number of samples averaged, as a shift amount (0 means one sample).
  function [2:0] shift_of;
    input [2:0] code;
    begin
      shift_of = code;
    end
  endfunction

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  localparam ST_IDLE = 2'h0;
  localparam ST_MEAS = 2'h1;
  localparam ST_EVAL = 2'h2;
  localparam ST_DONE = 2'h3;

  reg  [7:0]  cfg_q;          // Target code, auto decrement, average count.
  reg  [7:0]  ctrl_q;         // Calibration control, start and type.
  reg  [7:0]  ien_q;          // Interrupt enables and proximity mode.
  reg  [7:0]  mavg_q;         // Moving average select in bits 1:0.
  reg         dec_flag_q;     // Offset decremented flag.
  reg  [1:0]  state_q;        // Calibration sequencer state.
  reg  [3:0]  bit_q;          // Search step; 8 is the sign step.
  reg  [7:0]  trial_q;        // Trial magnitude during the search.
  reg         trial_sign_q;   // Trial sign during the search.
  reg  [7:0]  smp_cnt_q;      // Samples taken in the current average.
  reg  [16:0] acc_q;          // Sample accumulator.
  reg         prox_level_q;   // Last proximity event level, for state mode.
  reg         auto_en_prev_q; // Previous auto decrement enable.

  wire [7:0]  n_samples = 8'h01 << shift_of(cfg_q[2:0]);
  wire [16:0] acc_sum   = acc_q + {7'h00, adc_sample};
  wire [9:0]  avg_val   = acc_sum[9:0] >> 0;
  wire [16:0] avg_shift = acc_sum >> shift_of(cfg_q[2:0]);
  wire        last_smp  = (smp_cnt_q + 8'h01) == n_samples;
  wire        cal_start = reg_wr && reg_addr == `POC_ADDR_CALIB_CTRL && reg_wdata[`POC_CTRL_START_BIT];
  wire        stat_wr   = reg_wr && reg_addr == `POC_ADDR_CALIB_STAT;
  wire        zero_hit  = proximity_result_valid && proximity_result == 10'h000;

  // --------------------------------------------------------------------------
  // Register writes
  // --------------------------------------------------------------------------
  // Reserved fields are stored as written; the host keeps them at defaults.
  always @(posedge clk) begin
    if (srst) begin
      cfg_q  <= `POC_RST_CALIB_CFG;
      ien_q  <= `POC_RST_INT_EN;
      mavg_q <= `POC_RST_MAVG;
    end else if (reg_wr) begin
      case (reg_addr)
        `POC_ADDR_CALIB_CFG: cfg_q  <= reg_wdata;
        `POC_ADDR_INT_EN:    ien_q  <= reg_wdata;
        `POC_ADDR_MAVG:      mavg_q <= reg_wdata;
        default: ;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Calibration sequencer and sample averaging
  // --------------------------------------------------------------------------
  // One measurement per step: the sign step first, then magnitude bits 7 to 0.
  always @(posedge clk) begin
    if (srst) begin
      ctrl_q               <= `POC_RST_CALIB_CTRL;
      state_q              <= ST_IDLE;
      bit_q                <= 4'h0;
      trial_q              <= 8'h00;
      trial_sign_q         <= 1'b0;
      smp_cnt_q            <= 8'h00;
      acc_q                <= 17'h00000;
      sample_req_q         <= 1'b0;
      photodiode_connect_q <= 1'b1;
      avg_out_q            <= 10'h000;
      avg_valid_q          <= 1'b0;
      avg_to_filter_q      <= 1'b0;
      calib_busy_q         <= 1'b0;
    end else begin
      avg_valid_q  <= 1'b0;
      sample_req_q <= 1'b0;
      if (reg_wr && reg_addr == `POC_ADDR_CALIB_CTRL) begin
        ctrl_q <= reg_wdata;
      end
      // Each sample request makes the emitter fire its programmed pulse train.
      if (adc_valid) begin
        if (last_smp) begin
          smp_cnt_q   <= 8'h00;
          acc_q       <= 17'h00000;
          avg_out_q   <= (cfg_q[2:0] == 3'h0) ? avg_val : avg_shift[9:0];
          avg_valid_q <= !calib_busy_q;
          avg_to_filter_q <= mavg_q[1:0] != 2'h0;
        end else begin
          smp_cnt_q    <= smp_cnt_q + 8'h01;
          acc_q        <= acc_sum;
          sample_req_q <= 1'b1;
        end
      end
      case (state_q)
        ST_IDLE: begin
          if (cal_start) begin
            state_q              <= ST_MEAS;
            calib_busy_q         <= 1'b1;
            bit_q                <= 4'h8;
            trial_q              <= 8'h00;
            trial_sign_q         <= 1'b0;
            sample_req_q         <= 1'b1;
            photodiode_connect_q <= !reg_wdata[`POC_CTRL_ELEC_BIT];
          end
        end
        ST_MEAS: begin
          // Result arrives with the trial offset applied by the front end.
          if (proximity_result_valid) begin
            state_q <= ST_EVAL;
          end
        end
        ST_EVAL: begin
          // More offset is needed on that bit when the result is too high while subtracting, or too low while adding.
          if (bit_q == 4'h8) begin
            trial_sign_q <= proximity_result < target_of(cfg_q[7:5]);
            trial_q      <= 8'h80;
            bit_q        <= 4'h7;
            state_q      <= ST_MEAS;
            sample_req_q <= 1'b1;
          end else begin
            if (trial_sign_q ? (proximity_result > target_of(cfg_q[7:5]))
                             : (proximity_result < target_of(cfg_q[7:5]))) begin
              trial_q[bit_q[2:0]] <= 1'b0;
            end
            if (bit_q == 4'h0) begin
              state_q <= ST_DONE;
            end else begin
              trial_q[bit_q[2:0] - 3'h1] <= 1'b1;
              bit_q        <= bit_q - 4'h1;
              state_q      <= ST_MEAS;
              sample_req_q <= 1'b1;
            end
          end
        end
        ST_DONE: begin
          state_q              <= ST_IDLE;
          calib_busy_q         <= 1'b0;
          photodiode_connect_q <= 1'b1;
          ctrl_q[`POC_CTRL_START_BIT] <= 1'b0;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Offset registers and automatic decrement
  // --------------------------------------------------------------------------
  // The search drives the trial value; the final one is kept at completion.
  always @(posedge clk) begin
    if (srst) begin
      offset_magnitude_q <= 8'h00;
      offset_sign_q      <= 1'b0;
    end else if (state_q == ST_DONE) begin
      offset_magnitude_q <= trial_q;
      offset_sign_q      <= trial_sign_q;
    end else if (calib_busy_q) begin
      offset_magnitude_q <= trial_q;
      offset_sign_q      <= trial_sign_q;
    end else if (cfg_q[`POC_CFG_AUTO_BIT] && zero_hit && offset_magnitude_q != 8'h00) begin
      offset_magnitude_q <= offset_magnitude_q - 8'h01;
    end else if (reg_wr && reg_addr == `POC_ADDR_OFFSET_MAG) begin
      offset_magnitude_q <= reg_wdata;
    end else if (reg_wr && reg_addr == `POC_ADDR_OFFSET_SIGN) begin
      offset_sign_q <= reg_wdata[0];
    end
  end

  // --------------------------------------------------------------------------
  // Status flags
  // --------------------------------------------------------------------------
  // Hardware set wins over a clear arriving in the same cycle.
  always @(posedge clk) begin
    if (srst) begin
      dec_flag_q               <= 1'b0;
      calibration_irq_status_q <= 1'b0;
      auto_en_prev_q           <= 1'b0;
    end else begin
      auto_en_prev_q <= cfg_q[`POC_CFG_AUTO_BIT];
      if (!calib_busy_q && cfg_q[`POC_CFG_AUTO_BIT] && zero_hit && offset_magnitude_q != 8'h00) begin
        dec_flag_q <= 1'b1;
      end else if (!cfg_q[`POC_CFG_AUTO_BIT] ||
                   (stat_wr && reg_wdata[`POC_STAT_DEC_BIT])) begin
        dec_flag_q <= 1'b0;
      end
      if (state_q == ST_DONE) begin
        calibration_irq_status_q <= 1'b1;
      end else if (calibration_irq_clear) begin
        calibration_irq_status_q <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Proximity status and interrupt output
  // --------------------------------------------------------------------------
  // Level mode sets while the event stands; state mode sets only on a change.
  always @(posedge clk) begin
    if (srst) begin
      prox_level_q           <= 1'b0;
      proximity_irq_status_q <= 1'b0;
      irq_n_q                <= 1'b1;
    end else begin
      prox_level_q <= prox_event;
      if (ien_q[`POC_IEN_MODE_BIT] ? (prox_event != prox_level_q) : prox_event) begin
        proximity_irq_status_q <= 1'b1;
      end else if (calibration_irq_clear) begin
        proximity_irq_status_q <= 1'b0;
      end
      irq_n_q <= !((ien_q[`POC_IEN_PROX_BIT] && proximity_irq_status_q) ||
                   (ien_q[`POC_IEN_SAT_BIT]  && sat_event) ||
                   (ien_q[`POC_IEN_CAL_BIT]  && calibration_irq_status_q) ||
                   (ien_q[`POC_IEN_ZERO_BIT] && zero_event));
    end
  end

  // --------------------------------------------------------------------------
  // Register reads
  // --------------------------------------------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `POC_ADDR_CALIB_CFG:   reg_rdata_q <= cfg_q;
        `POC_ADDR_CALIB_CTRL:  reg_rdata_q <= ctrl_q;
        `POC_ADDR_CALIB_STAT:  reg_rdata_q <= {5'h00, dec_flag_q, 1'b0, calibration_irq_status_q};
        `POC_ADDR_INT_EN:      reg_rdata_q <= ien_q;
        `POC_ADDR_MAVG:        reg_rdata_q <= mavg_q;
        `POC_ADDR_OFFSET_MAG:  reg_rdata_q <= offset_magnitude_q;
        `POC_ADDR_OFFSET_SIGN: reg_rdata_q <= {7'h00, offset_sign_q};
        `POC_ADDR_LOT_LOW:     reg_rdata_q <= `POC_LOT_LOW_VALUE;
        default:               reg_rdata_q <= 8'h00;
      endcase
    end
  end
endmodule // poc_calib

// file: dv/poc_calib_sva.sv
// Port checker of the calibration block.
`include "poc_map.vh"
module poc_calib_sva (
  input wire       clk,
  input wire       srst,
  input wire       reg_wr,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       photodiode_connect_q,
  input wire       calib_busy_q,
  input wire       calibration_irq_status_q,
  input wire       calibration_irq_clear,
  input wire [7:0] offset_magnitude_q,
  input wire       proximity_irq_status_q,
  input wire       sat_event,
  input wire       zero_event,
  input wire       irq_n_q
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // A start write that the idle block must take.
  wire start_wr = reg_wr && reg_addr == `POC_ADDR_CALIB_CTRL && !calib_busy_q && reg_wdata[0];
  a_start_busy: assert property (start_wr |=> calib_busy_q) else $error("start not taken");
  a_elec_split: assert property (start_wr && reg_wdata[5] |=> !photodiode_connect_q) else $error("diode on");
  a_diode_held: assert property (calib_busy_q && $past(calib_busy_q) |-> $stable(photodiode_connect_q))
    else $error("diode moved in run");
  a_diode_idle: assert property (!calib_busy_q && !$past(calib_busy_q) |-> photodiode_connect_q)
    else $error("diode off when idle");
  a_done_flag: assert property ($fell(calib_busy_q) |-> calibration_irq_status_q) else $error("no done flag");
  a_search_bound: assert property ($rose(calib_busy_q) |-> ##[1:1000] !calib_busy_q) else $error("search hangs");
  a_clear_flag: assert property (calibration_irq_clear && !calib_busy_q |=> !calibration_irq_status_q)
    else $error("flag not cleared");
  // Outside a run and after no register write, only a decrement by one may move the magnitude; zero never wraps.
  a_dec_by_one: assert property (!calib_busy_q && !$past(calib_busy_q) && !$past(reg_wr) && $changed(offset_magnitude_q)
    |-> offset_magnitude_q == $past(offset_magnitude_q) - 1) else $error("bad decrement");
  a_irq_quiet: assert property ((!calibration_irq_status_q && !proximity_irq_status_q && !sat_event && !zero_event)[*3]
    |-> irq_n_q) else $error("irq without source");
  c_run_done: cover property ($fell(calib_busy_q));
  c_elec_run: cover property (start_wr && reg_wdata[5]);
  c_irq_low: cover property (!irq_n_q);
endmodule // poc_calib_sva

// file: dv/poc_front_model.sv
// Front end model answering each sample request with an offset-corrected result.
module poc_front_model #(
  parameter int LAT = 3
) (
  input  wire        clk,
  input  wire        srst,
  input  wire        sample_req_q,
  input  wire        photodiode_connect_q,
  input  wire [7:0]  offset_magnitude_q,
  input  wire        offset_sign_q,
  input  wire        kick,
  input  wire [9:0]  x_opt,
  input  wire [9:0]  x_elec,
  output logic [9:0] adc_sample,
  output logic       adc_valid,
  output logic [9:0] proximity_result,
  output logic       proximity_result_valid,
  output logic       zero_event
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  int v;
  logic [9:0] r;
  // Sample data toggles between answers so a stale sample is never mistaken for a fresh one.
  // The result holds like a result register, since the search evaluates it a cycle after its strobe.
  always @(posedge clk) begin
    adc_valid <= 1'b0;
    proximity_result_valid <= 1'b0;
    adc_sample <= ~adc_sample;
    if (srst) begin
      cnt <= 0;
      zero_event <= 1'b0;
    end else if (sample_req_q || kick) begin
      cnt <= LAT;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
    if (!srst && cnt == 1) begin
      v = int'(photodiode_connect_q ? x_opt : x_elec);
      v = offset_sign_q ? v + int'(offset_magnitude_q) : v - int'(offset_magnitude_q);
      r = v < 0 ? 10'h000 : (v > 1023 ? 10'h3ff : v[9:0]);
      adc_sample <= r;
      adc_valid <= 1'b1;
      proximity_result <= r;
      proximity_result_valid <= 1'b1;
      zero_event <= (r == 10'h000);
    end
  end
endmodule // poc_front_model

// file: dv/poc_calib_bench.sv
// Self-checking bench of the calibration block.
`include "poc_map.vh"
module poc_calib_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 1'b0;
  logic       srst = 1'b1;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       sat_event = 1'b0;
  logic       prox_event = 1'b0;
  logic       calibration_irq_clear = 1'b0;
  logic       kick = 1'b0;
  logic [9:0] x_opt = 10'h000;
  logic [9:0] x_elec = 10'h000;
  wire  [7:0] reg_rdata_q, offset_magnitude_q;
  wire  [9:0] adc_sample, avg_out_q, proximity_result;
  wire        sample_req_q, photodiode_connect_q, adc_valid, avg_valid_q, avg_to_filter_q, zero_event;
  wire        proximity_result_valid, offset_sign_q, calibration_irq_status_q, proximity_irq_status_q;
  wire        irq_n_q, calib_busy_q;
  int         bad_count = 0;
  int         num_checks = 0;
  int         cycles = 0;
  int         avg_seen = 0;
  int         smp_seen = 0;
  int         t;
  int         d;
  always #10 clk = ~clk;
  poc_calib uut (.clk(clk), .srst(srst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .sample_req_q(sample_req_q),
    .photodiode_connect_q(photodiode_connect_q), .adc_sample(adc_sample), .adc_valid(adc_valid),
    .avg_out_q(avg_out_q), .avg_valid_q(avg_valid_q), .avg_to_filter_q(avg_to_filter_q),
    .proximity_result(proximity_result),
    .proximity_result_valid(proximity_result_valid), .prox_event(prox_event), .sat_event(sat_event),
    .zero_event(zero_event), .calibration_irq_clear(calibration_irq_clear),
    .offset_magnitude_q(offset_magnitude_q), .offset_sign_q(offset_sign_q),
    .calibration_irq_status_q(calibration_irq_status_q), .proximity_irq_status_q(proximity_irq_status_q),
    .irq_n_q(irq_n_q), .calib_busy_q(calib_busy_q));
  poc_front_model fe (.clk(clk), .srst(srst), .sample_req_q(sample_req_q),
    .photodiode_connect_q(photodiode_connect_q), .offset_magnitude_q(offset_magnitude_q),
    .offset_sign_q(offset_sign_q), .kick(kick), .x_opt(x_opt), .x_elec(x_elec), .adc_sample(adc_sample),
    .adc_valid(adc_valid), .proximity_result(proximity_result),
    .proximity_result_valid(proximity_result_valid), .zero_event(zero_event));
  task automatic test_done();
    if (bad_count == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // A hung run counts as a mismatch.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      bad_count++;
      test_done();
    end
  end
  // Averages and converter samples seen, for the sample count checks.
  always @(posedge clk) begin
    if (avg_valid_q === 1'b1) avg_seen++;
    if (adc_valid === 1'b1) smp_seen++;
  end
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // Read data is registered, so it is looked at just after the edge that takes the read.
  task automatic rdchk(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(what, reg_rdata_q, exp);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic pulse_kick(input int n);
    @(posedge clk) kick <= 1'b1;
    @(posedge clk) kick <= 1'b0;
    settle(n);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    rdchk("cfg", `POC_ADDR_CALIB_CFG, 8'h50);
    rdchk("stat", `POC_ADDR_CALIB_STAT, 8'h00);
    rdchk("ien", `POC_ADDR_INT_EN, 8'h00);
    wr(`POC_ADDR_LOT_LOW, ~`POC_LOT_LOW_VALUE);
    rdchk("lot", `POC_ADDR_LOT_LOW, `POC_LOT_LOW_VALUE);
    rdchk("unmapped", 8'h01, 8'h00);
    wr(`POC_ADDR_INT_EN, 8'h3e);
    rdchk("ien", `POC_ADDR_INT_EN, 8'h3e);
    sat_event <= 1'b1;
    settle(3);
    chk("irq_sat", irq_n_q, 1'b0);
    wr(`POC_ADDR_INT_EN, 8'h00);
    settle(3);
    chk("irq_off", irq_n_q, 1'b1);
    sat_event <= 1'b0;
    // Every target code, alternating optical and electrical runs.
    for (int c = 0; c < 8; c++) begin
      x_opt <= (c == 7) ? 10'd300 : 10'd250;
      x_elec <= (c == 7) ? 10'd280 : 10'd230;
      wr(`POC_ADDR_CALIB_CFG, 8'((c << 5) | 8'h10));
      wr(`POC_ADDR_INT_EN, c[1] ? 8'h04 : 8'h00);
      wr(`POC_ADDR_CALIB_CTRL, c[0] ? 8'h21 : 8'h01);
      settle(2);
      for (int i = 0; i < 2000 && calib_busy_q !== 1'b0; i++) settle(1);
      settle(2);
      t = (4 << c) - 1;
      d = t - ((c == 7) ? 300 : 250) + (c[0] ? 20 : 0);
      chk("sign", offset_sign_q, d > 0);
      chk("mag", offset_magnitude_q, d > 0 ? d : -d);
      chk("cal_flag", calibration_irq_status_q, 1'b1);
      chk("irq_cal", irq_n_q, !c[1]);
      rdchk("stat_done", `POC_ADDR_CALIB_STAT, 8'h01);
      @(posedge clk) calibration_irq_clear <= 1'b1;
      @(posedge clk) calibration_irq_clear <= 1'b0;
      rdchk("stat_clr", `POC_ADDR_CALIB_STAT, 8'h00);
    end
    // Zero results walk the magnitude down and stop at zero.
    wr(`POC_ADDR_CALIB_CFG, 8'h58);
    wr(`POC_ADDR_OFFSET_MAG, 8'h02);
    wr(`POC_ADDR_OFFSET_SIGN, 8'h00);
    x_opt <= 10'h000;
    for (int k = 0; k < 3; k++) begin
      pulse_kick(8);
      chk("dec_mag", offset_magnitude_q, k < 2 ? 1 - k : 0);
    end
    wr(`POC_ADDR_INT_EN, 8'h02);
    settle(2);
    chk("irq_zero", irq_n_q, 1'b0);
    wr(`POC_ADDR_INT_EN, 8'h00);
    rdchk("dec_flag", `POC_ADDR_CALIB_STAT, 8'h04);
    wr(`POC_ADDR_CALIB_STAT, 8'h04);
    rdchk("w1c", `POC_ADDR_CALIB_STAT, 8'h00);
    wr(`POC_ADDR_OFFSET_MAG, 8'h01);
    pulse_kick(8);
    rdchk("dec_flag", `POC_ADDR_CALIB_STAT, 8'h04);
    wr(`POC_ADDR_CALIB_CFG, 8'h50);
    rdchk("dis_clr", `POC_ADDR_CALIB_STAT, 8'h00);
    // Averaging codes 0 to 3: samples per average, average value and its destination.
    x_opt <= 10'd100;
    for (int m = 0; m < 4; m++) begin
      wr(`POC_ADDR_MAVG, 8'(m));
      wr(`POC_ADDR_CALIB_CFG, 8'h50 | 8'(m));
      t = avg_seen;
      d = smp_seen;
      pulse_kick(50);
      chk("avg_cnt", avg_seen - t, 1);
      chk("smp_cnt", smp_seen - d, 1 << m);
      chk("avg_val", avg_out_q, 10'd100);
      chk("to_filter", avg_to_filter_q, m != 0);
    end
    // Level mode keeps setting while the event stands; state mode reacts only to a change.
    for (int p = 0; p < 2; p++) begin
      wr(`POC_ADDR_INT_EN, p ? 8'h30 : 8'h10);
      prox_event <= 1'b1;
      settle(3);
      chk("prox_set", proximity_irq_status_q, 1'b1);
      chk("irq_prox", irq_n_q, 1'b0);
      @(posedge clk) calibration_irq_clear <= 1'b1;
      @(posedge clk) calibration_irq_clear <= 1'b0;
      settle(3);
      chk("prox_hold", proximity_irq_status_q, !p);
      prox_event <= 1'b0;
      @(posedge clk) calibration_irq_clear <= 1'b1;
      @(posedge clk) calibration_irq_clear <= 1'b0;
      settle(3);
      chk("prox_clr", proximity_irq_status_q, 1'b0);
    end
    test_done();
  end
endmodule // poc_calib_bench
bind poc_calib poc_calib_sva chk_i (.clk(clk), .srst(srst), .reg_wr(reg_wr), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .photodiode_connect_q(photodiode_connect_q), .calib_busy_q(calib_busy_q),
  .calibration_irq_status_q(calibration_irq_status_q), .calibration_irq_clear(calibration_irq_clear),
  .offset_magnitude_q(offset_magnitude_q), .proximity_irq_status_q(proximity_irq_status_q),
  .sat_event(sat_event), .zero_event(zero_event), .irq_n_q(irq_n_q));
